/* hdl/irqp_top.sv */
// Interrupt output merge, pulse style, and serial pin function select
//
// Contract
// - Output A enables select its interrupt sources.
// - Output A bit 2 enables DAC overflow.
// - Single mode gives one 2 ms pulse.
// - Repeat mode: 2 ms pulses every 4 ms.
// - Train stops after both flag registers read.
// - Output B has own enables; bit 2 zero.
// - Output B bit 0 picks pulse style.
// - Keeper enabled when bit 4 clear; resets off.
// - Serial-out function select, reset audio data.
// - General-output mode drives written bit 0.
// - Serial-in mode select, reset audio use.
// - Serial-in bit 0 reads pin level.
// - Flags sticky; cleared by read; set wins.
`timescale 1ns/1ps
module irqp_top #(
	parameter logic [18:0] PULSE_CYC  = irqp_pkg::IRQP_PULSE_CYC,
	parameter logic [18:0] PERIOD_CYC = irqp_pkg::IRQP_PERIOD_CYC
) (
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                reset,
	// Register access from the control interface
	input  wire irqp_pkg::irqp_req_t req,
	output logic [7:0]               reg_rdata,
	// Source event pulses, same clock
	input  wire irqp_pkg::irqp_evt_t evt,
	// Signals offered to the serial-out pin
	input  wire logic                audio_data,
	input  wire logic                clock_output,
	input  wire logic                sec_bit_clk,
	input  wire logic                sec_word_clk,
	// Interrupt outputs
	output logic                     irq_out_a,
	output logic                     irq_out_b,
	// Serial-out pin
	output logic                     so_pin_o,
	output logic                     so_pin_oe,
	output logic                     so_keeper_en,
	// Serial-in pin
	input  wire logic                si_pin_i,
	output logic                     si_buf_en,
	output logic [1:0]               si_mode
);
	import irqp_pkg::*;

	// ==========================================================
	// Registers
	logic [7:0] ctrl_a_ff;
	logic [7:0] ctrl_b_ff;
	logic [7:0] spare_a_ff;
	logic [7:0] spare_b_ff;
	logic [7:0] so_ctrl_ff;
	logic [6:0] si_ctrl_ff;
	logic [7:0] rdata_ff, nxt_rdata;
	logic       si_meta_ff;
	logic       si_sync_ff;
	logic       wr_a, wr_b, wr_sa, wr_sb, wr_so, wr_si;
	logic       rd_dac, rd_adc;
	irqp_evt_t  flag_ff;
	logic [7:0] flag_dac, flag_adc;
	logic       trig_a, trig_b;
	logic       irq_a, irq_b;
	logic       so_o_ff, so_oe_ff, keeper_ff, si_en_ff;
	logic [1:0] si_mode_ff;

	assign wr_a   = req.wr && req.addr == IRQP_OFS_IRQ_A_CTRL;
	assign wr_b   = req.wr && req.addr == IRQP_OFS_IRQ_B_CTRL;
	assign wr_sa  = req.wr && req.addr == IRQP_OFS_SPARE_A;
	assign wr_sb  = req.wr && req.addr == IRQP_OFS_SPARE_B;
	assign wr_so  = req.wr && req.addr == IRQP_OFS_SO_CTRL;
	assign wr_si  = req.wr && req.addr == IRQP_OFS_SI_CTRL;
	assign rd_dac = req.rd && req.addr == IRQP_OFS_FLAG_DAC;
	assign rd_adc = req.rd && req.addr == IRQP_OFS_FLAG_ADC;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl_a_ff <= IRQP_RST_IRQ_CTRL;
			ctrl_b_ff <= IRQP_RST_IRQ_CTRL;
		end else begin
			if (wr_a) begin
				ctrl_a_ff <= req.wdata;
			end
			if (wr_b) begin
				// Bit 2 has no source on output B and stays zero
				ctrl_b_ff <= req.wdata & ~(8'h01 << IRQP_BIT_OVERFLOW);
			end
		end
	end

	// Spares simply hold what the host writes back into them
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			spare_a_ff <= IRQP_RST_SPARE;
			spare_b_ff <= IRQP_RST_SPARE;
		end else begin
			if (wr_sa) begin
				spare_a_ff <= req.wdata;
			end
			if (wr_sb) begin
				spare_b_ff <= req.wdata;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			so_ctrl_ff <= IRQP_RST_SO_CTRL;
			si_ctrl_ff <= IRQP_RST_SI_CTRL[7:1];
		end else begin
			if (wr_so) begin
				so_ctrl_ff <= req.wdata;
			end
			if (wr_si) begin
				si_ctrl_ff <= req.wdata[7:1];
			end
		end
	end

	// ==========================================================
	// Serial-in synchroniser
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			si_meta_ff <= 1'b0;
			si_sync_ff <= 1'b0;
		end else begin
			si_meta_ff <= si_pin_i;
			si_sync_ff <= si_meta_ff;
		end
	end

	// ==========================================================
	// Sticky flags
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			flag_ff <= '0;
		end else begin
			// A new event in the clearing cycle survives
			flag_ff.short_ckt <= (flag_ff.short_ckt & ~rd_dac) | evt.short_ckt;
			flag_ff.button    <= (flag_ff.button & ~rd_dac) | evt.button;
			flag_ff.headset   <= (flag_ff.headset & ~rd_dac) | evt.headset;
			flag_ff.dynamic_range_compressor       <= (flag_ff.dynamic_range_compressor & ~rd_dac) | evt.dynamic_range_compressor;
			flag_ff.overflow  <= (flag_ff.overflow & ~rd_dac) | evt.overflow;
			flag_ff.automatic_gain_control       <= (flag_ff.automatic_gain_control & ~rd_adc) | evt.automatic_gain_control;
			flag_ff.dcmeas    <= (flag_ff.dcmeas & ~rd_adc) | evt.dcmeas;
		end
	end

	always_comb begin
		flag_dac = 8'h00;
		flag_adc = 8'h00;
		flag_dac[IRQP_FD_SHORT]    = flag_ff.short_ckt;
		flag_dac[IRQP_FD_BUTTON]   = flag_ff.button;
		flag_dac[IRQP_FD_HEADSET]  = flag_ff.headset;
		flag_dac[IRQP_FD_DRC]      = flag_ff.dynamic_range_compressor;
		flag_dac[IRQP_FD_OVERFLOW] = flag_ff.overflow;
		flag_adc[IRQP_FA_AGC]      = flag_ff.automatic_gain_control;
		flag_adc[IRQP_FA_DCMEAS]   = flag_ff.dcmeas;
	end

	// ==========================================================
	// Read port
	always_comb begin
		case (req.addr)
			IRQP_OFS_FLAG_DAC:   nxt_rdata = flag_dac;
			IRQP_OFS_FLAG_ADC:   nxt_rdata = flag_adc;
			IRQP_OFS_IRQ_A_CTRL: nxt_rdata = ctrl_a_ff;
			IRQP_OFS_IRQ_B_CTRL: nxt_rdata = ctrl_b_ff;
			IRQP_OFS_SPARE_A:    nxt_rdata = spare_a_ff;
			IRQP_OFS_SPARE_B:    nxt_rdata = spare_b_ff;
			IRQP_OFS_SO_CTRL:    nxt_rdata = so_ctrl_ff;
			IRQP_OFS_SI_CTRL:    nxt_rdata = {si_ctrl_ff, si_sync_ff};
			default:             nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdata_ff <= 8'h00;
		end else if (req.rd) begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ==========================================================
	// Interrupt triggers and pulse generators
	function automatic logic irqp_hit(input logic [7:0] en,
			input irqp_evt_t e);
		irqp_hit = (en[IRQP_BIT_HEADSET] & e.headset)
			| (en[IRQP_BIT_BUTTON] & e.button)
			| (en[IRQP_BIT_DRC] & e.dynamic_range_compressor)
			| (en[IRQP_BIT_AGC] & e.automatic_gain_control)
			| (en[IRQP_BIT_SHORT] & e.short_ckt)
			| (en[IRQP_BIT_OVERFLOW] & e.overflow)
			| (en[IRQP_BIT_DCMEAS] & e.dcmeas);
	endfunction

	assign trig_a = irqp_hit(ctrl_a_ff, evt);
	assign trig_b = irqp_hit(ctrl_b_ff, evt);

	irqp_pulse_gen u_gen_a (
		.clk_sys    (clk_sys),
		.reset      (reset),
		.trig       (trig_a),
		.rpt        (ctrl_a_ff[IRQP_BIT_REPEAT]),
		.rd_dac     (rd_dac),
		.rd_adc     (rd_adc),
		.pulse_cyc  (PULSE_CYC),
		.period_cyc (PERIOD_CYC),
		.irq        (irq_a)
	);

	irqp_pulse_gen u_gen_b (
		.clk_sys    (clk_sys),
		.reset      (reset),
		.trig       (trig_b),
		.rpt        (ctrl_b_ff[IRQP_BIT_REPEAT]),
		.rd_dac     (rd_dac),
		.rd_adc     (rd_adc),
		.pulse_cyc  (PULSE_CYC),
		.period_cyc (PERIOD_CYC),
		.irq        (irq_b)
	);

	// ==========================================================
	// Pin function select
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			so_o_ff    <= 1'b0;
			so_oe_ff   <= 1'b0;
			keeper_ff  <= 1'b0;
			si_en_ff   <= 1'b1;
			si_mode_ff <= IRQP_RST_SI_CTRL[2:1];
		end else begin
			keeper_ff  <= ~so_ctrl_ff[IRQP_BIT_KEEPER_N];
			si_mode_ff <= si_ctrl_ff[1:0];
			si_en_ff   <= si_ctrl_ff[1:0] != IRQP_SI_OFF;
			so_oe_ff   <= so_ctrl_ff[3:1] != IRQP_SO_OFF;
			case (so_ctrl_ff[3:1])
				IRQP_SO_AUDIO: so_o_ff <= audio_data;
				IRQP_SO_GPO:   so_o_ff <= so_ctrl_ff[IRQP_BIT_GPO];
				IRQP_SO_CLK:   so_o_ff <= clock_output;
				IRQP_SO_IRQA:  so_o_ff <= irq_a;
				IRQP_SO_IRQB:  so_o_ff <= irq_b;
				IRQP_SO_BCLK:  so_o_ff <= sec_bit_clk;
				IRQP_SO_WCLK:  so_o_ff <= sec_word_clk;
				default:       so_o_ff <= 1'b0;
			endcase
		end
	end

	assign reg_rdata    = rdata_ff;
	assign irq_out_a    = irq_a;
	assign irq_out_b    = irq_b;
	assign so_pin_o     = so_o_ff;
	assign so_pin_oe    = so_oe_ff;
	assign so_keeper_en = keeper_ff;
	assign si_buf_en    = si_en_ff;
	assign si_mode      = si_mode_ff;

	// ==========================================================
	// Checks
	a_keeper_follows_bit:
	assert property (@(posedge clk_sys) disable iff (reset)
		wr_so ##2 1 |-> so_keeper_en == !$past(req.wdata[IRQP_BIT_KEEPER_N], 2))
	else $error("keeper enable not inverse of control bit");

	a_gpo_drives_pin:
	assert property (@(posedge clk_sys) disable iff (reset)
		wr_so && req.wdata[3:1] == IRQP_SO_GPO ##1 !wr_so
		|=> so_pin_oe && so_pin_o == $past(req.wdata[0], 2))
	else $error("general output value not on pin");

	a_out_b_bit2_zero:
	assert property (@(posedge clk_sys) disable iff (reset)
		req.rd && req.addr == IRQP_OFS_IRQ_B_CTRL |=> !reg_rdata[2])
	else $error("output B reserved bit reads nonzero");

	a_sticky_set_wins:
	assert property (@(posedge clk_sys) disable iff (reset)
		rd_dac && evt.button |=> flag_ff.button)
	else $error("event lost during flag clear");

	a_si_level_read:
	assert property (@(posedge clk_sys) disable iff (reset)
		req.rd && req.addr == IRQP_OFS_SI_CTRL
		|=> reg_rdata[0] == $past(si_pin_i, 3))
	else $error("serial-in level read back wrong");

	a_irq_idle_low:
	assert property (@(posedge clk_sys) disable iff (reset)
		!$past(trig_a) && $rose(irq_out_a) |-> $past(u_gen_a.rpt_ff))
	else $error("output A rose with no event in single mode");

endmodule

/* hdl/irqp_pkg.sv */
// Package of constants and types for the interrupt pulse and pin select block
package irqp_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] IRQP_OFS_FLAG_DAC   = 8'h2C;
	localparam logic [7:0] IRQP_OFS_FLAG_ADC   = 8'h2D;
	localparam logic [7:0] IRQP_OFS_IRQ_A_CTRL = 8'h30;
	localparam logic [7:0] IRQP_OFS_IRQ_B_CTRL = 8'h31;
	localparam logic [7:0] IRQP_OFS_SPARE_A    = 8'h32;
	localparam logic [7:0] IRQP_OFS_SPARE_B    = 8'h34;
	localparam logic [7:0] IRQP_OFS_SO_CTRL    = 8'h35;
	localparam logic [7:0] IRQP_OFS_SI_CTRL    = 8'h36;

	// ==========================================================
	// Reset values
	localparam logic [7:0] IRQP_RST_IRQ_CTRL = 8'h00;
	localparam logic [7:0] IRQP_RST_SPARE    = 8'h00;
	localparam logic [7:0] IRQP_RST_SO_CTRL  = 8'h12;
	localparam logic [7:0] IRQP_RST_SI_CTRL  = 8'h02;

	// ==========================================================
	// Field positions
	localparam int IRQP_BIT_HEADSET   = 7;
	localparam int IRQP_BIT_BUTTON    = 6;
	localparam int IRQP_BIT_DRC       = 5;
	localparam int IRQP_BIT_AGC       = 4;
	localparam int IRQP_BIT_SHORT     = 3;
	localparam int IRQP_BIT_OVERFLOW  = 2;
	localparam int IRQP_BIT_DCMEAS    = 1;
	localparam int IRQP_BIT_REPEAT    = 0;
	localparam int IRQP_BIT_KEEPER_N  = 4;
	localparam int IRQP_BIT_GPO       = 0;
	// Flag register bit positions
	localparam int IRQP_FD_SHORT      = 7;
	localparam int IRQP_FD_BUTTON     = 5;
	localparam int IRQP_FD_HEADSET    = 4;
	localparam int IRQP_FD_DRC        = 3;
	localparam int IRQP_FD_OVERFLOW   = 1;
	localparam int IRQP_FA_AGC        = 6;
	localparam int IRQP_FA_DCMEAS     = 2;

	// ==========================================================
	// Pin function encodings
	localparam logic [2:0] IRQP_SO_OFF   = 3'h0;
	localparam logic [2:0] IRQP_SO_AUDIO = 3'h1;
	localparam logic [2:0] IRQP_SO_GPO   = 3'h2;
	localparam logic [2:0] IRQP_SO_CLK   = 3'h3;
	localparam logic [2:0] IRQP_SO_IRQA  = 3'h4;
	localparam logic [2:0] IRQP_SO_IRQB  = 3'h5;
	localparam logic [2:0] IRQP_SO_BCLK  = 3'h6;
	localparam logic [2:0] IRQP_SO_WCLK  = 3'h7;
	localparam logic [1:0] IRQP_SI_OFF   = 2'h0;

	// ==========================================================
	// Timing
	localparam int IRQP_CLK_KHZ     = 100000;
	localparam int IRQP_PULSE_MS    = 2;
	localparam int IRQP_PERIOD_MS   = 4;
	localparam int IRQP_CNT_W       = 19;
	localparam logic [IRQP_CNT_W-1:0] IRQP_PULSE_CYC =
		IRQP_CNT_W'(IRQP_PULSE_MS * IRQP_CLK_KHZ);
	localparam logic [IRQP_CNT_W-1:0] IRQP_PERIOD_CYC =
		IRQP_CNT_W'(IRQP_PERIOD_MS * IRQP_CLK_KHZ);

	// ==========================================================
	// Types
	typedef struct packed {
		logic headset;
		logic button;
		logic dynamic_range_compressor;
		logic automatic_gain_control;
		logic short_ckt;
		logic overflow;
		logic dcmeas;
	} irqp_evt_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} irqp_req_t;

endpackage

/* hdl/irqp_pulse_gen.sv */
// Single or repeating interrupt pulse generator for one output
`timescale 1ns/1ps
module irqp_pulse_gen (
	// Clock and reset
	input  wire logic                          clk_sys,
	input  wire logic                          reset,
	// Control
	input  wire logic                          trig,
	input  wire logic                          rpt,
	input  wire logic                          rd_dac,
	input  wire logic                          rd_adc,
	input  wire logic [irqp_pkg::IRQP_CNT_W-1:0] pulse_cyc,
	input  wire logic [irqp_pkg::IRQP_CNT_W-1:0] period_cyc,
	// Output
	output logic                               irq
);
	import irqp_pkg::*;

	typedef enum logic {ST_IDLE, ST_RUN} irqp_gen_st_t;

	irqp_gen_st_t          st_ff, nxt_st;
	logic [IRQP_CNT_W-1:0] cnt_ff, nxt_cnt;
	logic                  rpt_ff;
	logic                  seen_dac_ff;
	logic                  seen_adc_ff;
	logic                  irq_ff;
	logic                  high_phase_end;

	assign high_phase_end = cnt_ff >= pulse_cyc - IRQP_CNT_W'(1);

	// ==========================================================
	// Sequencing
	always_comb begin
		nxt_st  = st_ff;
		nxt_cnt = cnt_ff;
		case (st_ff)
			ST_IDLE: begin
				nxt_cnt = '0;
				if (trig) begin
					nxt_st = ST_RUN;
				end
			end
			ST_RUN: begin
				// Later events neither restart nor stretch
				if (cnt_ff == period_cyc - IRQP_CNT_W'(1)) begin
					nxt_cnt = '0;
				end else begin
					nxt_cnt = cnt_ff + IRQP_CNT_W'(1);
				end
				if (!rpt_ff && high_phase_end) begin
					nxt_st = ST_IDLE;
				end else if (rpt_ff && seen_dac_ff && seen_adc_ff
						&& high_phase_end) begin
					// Train ends cleanly, never cutting a pulse short
					nxt_st = ST_IDLE;
				end
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_ff  <= ST_IDLE;
			cnt_ff <= '0;
		end else begin
			st_ff  <= nxt_st;
			cnt_ff <= (nxt_st == ST_RUN) ? nxt_cnt : '0;
		end
	end

	// Mode is latched at start so a write mid-train cannot corrupt it
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rpt_ff <= 1'b0;
		end else if (st_ff == ST_IDLE && trig) begin
			rpt_ff <= rpt;
		end
	end

	// Both flag registers must be read before a train stops
	always_ff @(posedge clk_sys) begin
		if (reset || (st_ff == ST_IDLE && trig)) begin
			seen_dac_ff <= 1'b0;
			seen_adc_ff <= 1'b0;
		end else begin
			seen_dac_ff <= seen_dac_ff | rd_dac;
			seen_adc_ff <= seen_adc_ff | rd_adc;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= (nxt_st == ST_RUN) && (nxt_cnt < pulse_cyc);
		end
	end

	assign irq = irq_ff;

	// ==========================================================
	// Checks
	logic [IRQP_CNT_W-1:0] high_len_ff;
	always_ff @(posedge clk_sys) begin
		if (reset || !irq_ff) begin
			high_len_ff <= '0;
		end else begin
			high_len_ff <= high_len_ff + IRQP_CNT_W'(1);
		end
	end

	a_pulse_width_cap:
	assert property (@(posedge clk_sys) disable iff (reset)
		high_len_ff <= pulse_cyc)
	else $error("interrupt pulse longer than its width");

	a_pulse_exact_len:
	assert property (@(posedge clk_sys) disable iff (reset)
		$fell(irq_ff) |-> high_len_ff == pulse_cyc)
	else $error("interrupt pulse ended at wrong length");

	a_rise_needs_cause:
	assert property (@(posedge clk_sys) disable iff (reset)
		$rose(irq_ff) |-> $past(trig) || $past(rpt_ff))
	else $error("interrupt pulse without event or train");

endmodule

/* bench/irqp_host_model.sv */
// Host processor model: register requests toward the block
`timescale 1ns/1ps
module irqp_host_model (
	// Clock
	input  wire logic           clk_sys,
	// Register port
	output irqp_pkg::irqp_req_t req,
	input  wire logic [7:0]     reg_rdata
);
	import irqp_pkg::*;

	initial req = '0;

	// ==========================================================
	// Register access
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		// Spares only ever receive their reset value
		v = d;
		if (a == IRQP_OFS_SPARE_A || a == IRQP_OFS_SPARE_B)
			v = IRQP_RST_SPARE;
		@(posedge clk_sys);
		req <= '{a, v, 1'b1, 1'b0};
		@(posedge clk_sys);
		req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		req.rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
endmodule

/* bench/testbench.sv */
// Self-checking testbench for the interrupt pulse and pin select block
`timescale 1ns/1ps
module testbench;
	import irqp_pkg::*;

	// Short counts keep the pulse trains brief
	localparam logic [18:0] PULSE  = 19'h0_0004;
	localparam logic [18:0] PERIOD = 19'h0_0008;

	logic       clk_sys, reset, si_pin_i;
	logic       audio_data, clock_output, sec_bit_clk, sec_word_clk;
	irqp_evt_t  evt;
	irqp_req_t  req;
	logic [7:0] reg_rdata, d;
	logic       irq_out_a, irq_out_b, so_pin_o, so_pin_oe;
	logic       so_keeper_en, si_buf_en;
	logic [1:0] si_mode;
	int         error_cnt, samples_checked, w, lat;

	irqp_top #(.PULSE_CYC(PULSE), .PERIOD_CYC(PERIOD)) uut (
		.clk_sys(clk_sys), .reset(reset), .req(req),
		.reg_rdata(reg_rdata), .evt(evt), .audio_data(audio_data),
		.clock_output(clock_output), .sec_bit_clk(sec_bit_clk),
		.sec_word_clk(sec_word_clk), .irq_out_a(irq_out_a),
		.irq_out_b(irq_out_b), .so_pin_o(so_pin_o),
		.so_pin_oe(so_pin_oe), .so_keeper_en(so_keeper_en),
		.si_pin_i(si_pin_i), .si_buf_en(si_buf_en), .si_mode(si_mode)
	);

	irqp_host_model host (
		.clk_sys(clk_sys), .req(req), .reg_rdata(reg_rdata)
	);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// ==========================================================
	// Shared helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
			input string m);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, d);
		chk(d, exp, "read data");
	endtask

	// Fires an event, optionally again mid-pulse; counts high cycles
	task automatic fire(input irqp_evt_t e, input logic b,
			input logic again, output int wd, output int lt);
		wd = 0;
		lt = -1;
		@(posedge clk_sys);
		evt <= e;
		for (int i = 0; i < 24; i++) begin
			@(posedge clk_sys);
			evt <= (again && i == 2) ? e : '0;
			#1;
			if ((b ? irq_out_b : irq_out_a) === 1'b1) begin
				if (lt < 0)
					lt = i;
				wd++;
			end
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		rchk(IRQP_OFS_IRQ_A_CTRL, 8'h00);
		rchk(IRQP_OFS_IRQ_B_CTRL, 8'h00);
		rchk(IRQP_OFS_SO_CTRL, 8'h12);
		rchk(IRQP_OFS_SI_CTRL, 8'h02);
		rchk(8'h37, 8'h00);
		chk(8'(so_keeper_en), 8'h00, "keeper");
		chk(8'(so_pin_oe), 8'h01, "out enable");
		chk(8'(si_mode), 8'h01, "in mode");
		chk(8'(si_buf_en), 8'h01, "in buffer");
		chk(8'(irq_out_a | irq_out_b), 8'h00, "idle");
		host.wr(IRQP_OFS_SPARE_A, 8'hA5);
		rchk(IRQP_OFS_SPARE_A, 8'h00);
		$display("t_reset done");
	endtask

	task automatic t_sources;
		logic [7:0] m;
		for (int b = 0; b < 2; b++) begin
			for (int j = 0; j < 7; j++) begin
				m = 8'h01 << (j + 1);
				host.wr(IRQP_OFS_IRQ_A_CTRL, b ? 8'h00 : m);
				host.wr(IRQP_OFS_IRQ_B_CTRL, b ? m : 8'h00);
				if (b)
					rchk(IRQP_OFS_IRQ_B_CTRL, (j == 1) ? 8'h00 : m);
				fire(7'h01 << j, b[0], 1'b1, w, lat);
				if (b && j == 1) begin
					chk(8'(w), 8'h00, "no overflow on b");
				end else begin
					chk(8'(w), 8'(PULSE), "width");
					chk(8'(lat), 8'h00, "latency");
				end
				fire(~(7'h01 << j), b[0], 1'b0, w, lat);
				chk(8'(w), 8'h00, "masked source");
			end
		end
		$display("t_sources done");
	endtask

	task automatic t_repeat;
		for (int b = 0; b < 2; b++) begin
			host.wr(IRQP_OFS_IRQ_A_CTRL, b ? 8'h00 : 8'h41);
			host.wr(IRQP_OFS_IRQ_B_CTRL, b ? 8'h41 : 8'h00);
			fire(7'h20, b[0], 1'b0, w, lat);
			chk(8'(w), 8'(3 * PULSE), "train");
			host.rd(IRQP_OFS_FLAG_DAC, d);
			host.rd(IRQP_OFS_FLAG_ADC, d);
			repeat (8) @(posedge clk_sys);
			fire('0, b[0], 1'b0, w, lat);
			chk(8'(w), 8'h00, "train stopped");
		end
		$display("t_repeat done");
	endtask

	task automatic t_flags;
		host.rd(IRQP_OFS_FLAG_DAC, d);
		host.rd(IRQP_OFS_FLAG_ADC, d);
		fire(7'h48, 1'b0, 1'b0, w, lat);
		rchk(IRQP_OFS_FLAG_DAC, 8'h10);
		rchk(IRQP_OFS_FLAG_DAC, 8'h00);
		rchk(IRQP_OFS_FLAG_ADC, 8'h40);
		rchk(IRQP_OFS_FLAG_ADC, 8'h00);
		// Event lands in the very cycle the flag register is read
		host.wr(IRQP_OFS_IRQ_B_CTRL, 8'h00);
		fork
			host.rd(IRQP_OFS_FLAG_DAC, d);
			begin
				@(posedge clk_sys);
				evt <= 7'h20;
				@(posedge clk_sys);
				evt <= '0;
			end
		join
		chk(d, 8'h00, "flags before event");
		rchk(IRQP_OFS_FLAG_DAC, 8'h20);
		$display("t_flags done");
	endtask

	task automatic t_pins;
		logic [2:0] f;
		logic       e;
		for (int k = 0; k < 8; k++) begin
			f = 3'(k);
			e = (f != IRQP_SO_IRQA && f != IRQP_SO_IRQB);
			host.wr(IRQP_OFS_SO_CTRL, {4'h1, f, 1'b1});
			@(posedge clk_sys);
			audio_data <= (f == IRQP_SO_AUDIO);
			clock_output <= (f == IRQP_SO_CLK);
			sec_bit_clk <= (f == IRQP_SO_BCLK);
			sec_word_clk <= (f == IRQP_SO_WCLK);
			repeat (3) @(posedge clk_sys);
			#1;
			chk(8'(so_pin_oe), 8'(f != IRQP_SO_OFF), "pin enable");
			if (f != IRQP_SO_OFF)
				chk(8'(so_pin_o), 8'(e), "pin level");
		end
		host.wr(IRQP_OFS_SO_CTRL, 8'h04);
		repeat (3) @(posedge clk_sys);
		#1;
		chk(8'(so_pin_o), 8'h00, "gpo low");
		chk(8'(so_keeper_en), 8'h01, "keeper on");
		host.wr(IRQP_OFS_SO_CTRL, IRQP_RST_SO_CTRL);
		$display("t_pins done");
	endtask

	task automatic t_serial_in;
		host.wr(IRQP_OFS_SI_CTRL, 8'h00);
		repeat (3) @(posedge clk_sys);
		#1;
		chk(8'(si_buf_en), 8'h00, "buffer off");
		host.wr(IRQP_OFS_SI_CTRL, 8'h05);
		rchk(IRQP_OFS_SI_CTRL, 8'h04);
		@(posedge clk_sys);
		si_pin_i <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rchk(IRQP_OFS_SI_CTRL, 8'h05);
		chk(8'(si_mode), 8'h02, "input mode");
		host.wr(IRQP_OFS_SI_CTRL, IRQP_RST_SI_CTRL);
		$display("t_serial_in done");
	endtask

	// ==========================================================
	// Verdict and run control
	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Whole run is about a thousand cycles; this margin is generous
	initial begin
		#200000;
		error_cnt++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		final_report;
	end

	initial begin
		reset = 1'b1;
		evt = '0;
		si_pin_i = 1'b0;
		audio_data = 1'b0;
		clock_output = 1'b0;
		sec_bit_clk = 1'b0;
		sec_word_clk = 1'b0;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		t_reset;
		t_sources;
		t_repeat;
		t_flags;
		t_pins;
		t_serial_in;
		final_report;
	end
endmodule
